/* logic/dsmc_monitor.sv */
// safety monitor of one servo axis: startup checks, encoder monitors, fail-safe reaction
// assumes CFG is stable while CFG_LOAD is high and all inputs are synchronous to CLK
`timescale 1ns/1ps

// Notes on behaviour
// R1 - auto restart enters operation alone; otherwise restart inhibit holds until acknowledged
// R2 - encoder position lag monitor, on by default, errors only while enabled
// R3 - encoder speed error monitor flags discrepancies only while enabled
// R4 - frozen setpoint monitor, off by default, flags a setpoint that stops changing
// R5 - default fail-safe drops both torque channels and engages brake at once
// R6 - delayed fail-safe drops channel one, then full torque and brake after delay
// R7 - delayed fail-safe drops channel two only after the brake engage delay
// R8 - holds maximum speed and four limited speed levels, default zero
// R9 - startup checks speed limits ascend; violation enters fail-safe immediately
// R10 - holds full travel and monitored range position limits, default zero
// R11 - startup checks position limits nest properly; violation enters fail-safe
// R12 - standstill judged against a configurable speed tolerance
// R13 - one position tolerance serves standstill and direction monitoring
// R14 - ordering checked once after load; fail-safe stays latched until reset
module dsmc_monitor #(
   parameter int FROZEN_CYCLES = 1000
) (
   input  wire logic                    CLK,
   input  wire logic                    RESET_N,
   input  wire dsmc_pkg::dsmc_cfg_type  CFG,
   input  wire logic                    CFG_LOAD,
   input  wire dsmc_pkg::dsmc_feed_type FEED,
   input  wire logic                    NET_LOSS,
   input  wire logic                    RESTART_ACK,
   output logic                         TORQUE_EN_CH1,
   output logic                         TORQUE_EN_CH2,
   output logic                         TORQUE_OFF_ALL,
   output logic                         BRAKE_CONTROL_ENGAGE,
   output logic                         FAILSAFE,
   output logic                         OPERATIONAL,
   output logic                         RESTART_INHIBIT,
   output logic                         POS_LAG_ERR,
   output logic                         SPEED_ERR,
   output logic                         FROZEN_ERR,
   output logic                         ORDER_ERR,
   output logic                         STANDSTILL_OK,
   output logic                         DIR_NEG_MOVE
);
   localparam int FRZ_W = $clog2(FROZEN_CYCLES + 1);

   typedef struct packed {
      dsmc_pkg::dsmc_state_type          st;
      dsmc_pkg::dsmc_cfg_type            cfg;
      logic [dsmc_pkg::DATA_W-1:0]       cnt;
      logic signed [dsmc_pkg::DATA_W-1:0] prev_set;
      logic [FRZ_W-1:0]                  frz_cnt;
      logic signed [dsmc_pkg::DATA_W-1:0] ss_ref;
      logic                              en1;
      logic                              en2;
      logic                              off_all;
      logic                              brake;
      logic                              failsafe;
      logic                              pos_err;
      logic                              spd_err;
      logic                              frz_err;
      logic                              order_err;
      logic                              standstill;
      logic                              dir_neg;
      logic                              op;
      logic                              inh;
   } dsmc_regs_type;

   dsmc_regs_type state_ff;
   dsmc_regs_type nxt_state;

   function automatic logic [dsmc_pkg::DATA_W-1:0] abs_diff(
      input logic signed [dsmc_pkg::DATA_W-1:0] a,
      input logic signed [dsmc_pkg::DATA_W-1:0] b
   );
      logic signed [dsmc_pkg::DATA_W:0] d;
      d = {a[dsmc_pkg::DATA_W-1], a} - {b[dsmc_pkg::DATA_W-1], b};
      return d[dsmc_pkg::DATA_W] ? dsmc_pkg::DATA_W'(-d) : dsmc_pkg::DATA_W'(d);
   endfunction : abs_diff

   function automatic logic [dsmc_pkg::DATA_W-1:0] us_to_cycles(
      input logic [dsmc_pkg::DELAY_W-1:0] us
   );
      return dsmc_pkg::DATA_W'(us) * dsmc_pkg::DATA_W'(dsmc_pkg::CYC_PER_US);
   endfunction : us_to_cycles

   // standstill tolerance below level four, levels falling from one to four, then top
   function automatic logic speed_order_ok(input dsmc_pkg::dsmc_cfg_type c);
      logic ok;
      ok = c.standstill_speed_tol <= c.limited_speed_level[dsmc_pkg::LEVELS-1];
      for (int i = 0; i < dsmc_pkg::LEVELS - 1; i++)
      begin
         ok = ok && (c.limited_speed_level[i+1] <= c.limited_speed_level[i]);
      end
      ok = ok && (c.limited_speed_level[0] <= c.max_speed_limit);
      return ok && (c.max_speed_limit <= c.normalised_top_speed);
   endfunction : speed_order_ok

   function automatic logic pos_order_ok(input dsmc_pkg::dsmc_cfg_type c);
      return (c.full_travel_lo <= c.monitored_range_lo) &&
             (c.monitored_range_lo <= c.monitored_range_hi) &&
             (c.monitored_range_hi <= c.full_travel_hi);
   endfunction : pos_order_ok

   logic lag_c;
   logic spd_dev_c;
   logic set_still_c;
   logic spd_in_c;
   logic order_ok_c;
   logic fault_c;

   always_comb
   begin
      nxt_state   = state_ff;
      lag_c       = abs_diff(FEED.enc_pos, FEED.set_pos) > state_ff.cfg.enc_pos_tol;
      spd_dev_c   = abs_diff(FEED.enc_speed, FEED.ref_speed) > state_ff.cfg.enc_speed_tol;
      set_still_c = FEED.set_pos == state_ff.prev_set;
      spd_in_c    = abs_diff(FEED.enc_speed, '0) <= state_ff.cfg.standstill_speed_tol;   // R12
      order_ok_c  = speed_order_ok(state_ff.cfg) && pos_order_ok(state_ff.cfg);      // R9 R11
      fault_c     = 1'b0;

      // frozen detection counts identical setpoint samples
      nxt_state.prev_set = FEED.set_pos;
      if (!set_still_c)
         nxt_state.frz_cnt = '0;
      else if (state_ff.frz_cnt != FRZ_W'(FROZEN_CYCLES))
         nxt_state.frz_cnt = state_ff.frz_cnt + FRZ_W'(1);

      // reference follows the axis until the speed settles
      if (!spd_in_c)
         nxt_state.ss_ref = FEED.enc_pos;
      nxt_state.standstill = spd_in_c &&
         abs_diff(FEED.enc_pos, state_ff.ss_ref) <= state_ff.cfg.standstill_pos_tol;   // R13
      nxt_state.dir_neg = (state_ff.ss_ref > FEED.enc_pos) &&
         abs_diff(state_ff.ss_ref, FEED.enc_pos) > state_ff.cfg.standstill_pos_tol;    // R13

      // monitors act only in operation, each gated by its own enable
      if (state_ff.st == dsmc_pkg::ST_RUN)
      begin
         if (state_ff.cfg.pos_mon_en && lag_c)                                      // R2
         begin
            nxt_state.pos_err = 1'b1;
            fault_c = 1'b1;
         end
         if (state_ff.cfg.spd_mon_en && spd_dev_c)                                  // R3
         begin
            nxt_state.spd_err = 1'b1;
            fault_c = 1'b1;
         end
         if (state_ff.cfg.frozen_mon_en && set_still_c &&
             state_ff.frz_cnt == FRZ_W'(FROZEN_CYCLES))                             // R4
         begin
            nxt_state.frz_err = 1'b1;
            fault_c = 1'b1;
         end
      end

      unique case (state_ff.st)
         dsmc_pkg::ST_LOAD:
         begin
            if (CFG_LOAD)
            begin
               nxt_state.cfg = CFG;                                                 // R8 R10
               nxt_state.st  = dsmc_pkg::ST_CHECK;
            end
         end
         dsmc_pkg::ST_CHECK:
         begin
            // evaluated once; a bad order never returns here before reset
            if (!order_ok_c)                                                        // R14
            begin
               nxt_state.order_err = 1'b1;
               fault_c = 1'b1;
            end
            else
               nxt_state.st = dsmc_pkg::ST_INHIBIT;
         end
         dsmc_pkg::ST_INHIBIT:
         begin
            if (!NET_LOSS && (state_ff.cfg.auto_restart || RESTART_ACK))           // R1
            begin
               nxt_state.st    = dsmc_pkg::ST_RUN;
               nxt_state.en1   = 1'b1;
               nxt_state.en2   = 1'b1;
               nxt_state.brake = 1'b0;
               nxt_state.off_all = 1'b0;
            end
         end
         dsmc_pkg::ST_RUN:
         begin
            if (NET_LOSS && !fault_c)                                               // R1
            begin
               nxt_state.st      = dsmc_pkg::ST_INHIBIT;
               nxt_state.en1     = 1'b0;
               nxt_state.en2     = 1'b0;
               nxt_state.brake   = 1'b1;
               nxt_state.off_all = 1'b1;
            end
         end
         dsmc_pkg::ST_FS_CH1_OFF:
         begin
            nxt_state.cnt = state_ff.cnt + dsmc_pkg::DATA_W'(1);
            if (state_ff.cnt >= us_to_cycles(state_ff.cfg.torque_off_delay_us))     // R6
            begin
               nxt_state.off_all = 1'b1;
               nxt_state.brake   = 1'b1;
               nxt_state.cnt     = '0;
               nxt_state.st      = dsmc_pkg::ST_FS_BRAKE;
            end
         end
         dsmc_pkg::ST_FS_BRAKE:
         begin
            nxt_state.cnt = state_ff.cnt + dsmc_pkg::DATA_W'(1);
            if (state_ff.cnt >= us_to_cycles(state_ff.cfg.brake_delay_us))          // R7
            begin
               nxt_state.en2 = 1'b0;
               nxt_state.st  = dsmc_pkg::ST_FS_HOLD;
            end
         end
         dsmc_pkg::ST_FS_HOLD:
            nxt_state.st = dsmc_pkg::ST_FS_HOLD;                                    // R14
         default:
            fault_c = 1'b1;
      endcase

      // any fault lands here; later faults cannot restart the reaction
      if (fault_c && !state_ff.failsafe)
      begin
         nxt_state.failsafe = 1'b1;
         nxt_state.en1      = 1'b0;
         nxt_state.cnt      = '0;
         if (state_ff.cfg.fs_delayed)                                               // R6
            nxt_state.st = dsmc_pkg::ST_FS_CH1_OFF;
         else
         begin
            nxt_state.en2     = 1'b0;                                               // R5
            nxt_state.off_all = 1'b1;
            nxt_state.brake   = 1'b1;
            nxt_state.st      = dsmc_pkg::ST_FS_HOLD;
         end
      end

      // state flags registered so the decoded outputs still come from flops
      nxt_state.op  = nxt_state.st == dsmc_pkg::ST_RUN;
      nxt_state.inh = nxt_state.st == dsmc_pkg::ST_INHIBIT;
   end

   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         state_ff         <= '0;
         state_ff.st      <= dsmc_pkg::ST_LOAD;
         state_ff.cfg     <= dsmc_pkg::CFG_RESET;                                   // R2 R4
         state_ff.brake   <= 1'b1;
         state_ff.off_all <= 1'b1;
      end
      else
         state_ff <= nxt_state;
   end

   assign TORQUE_EN_CH1        = state_ff.en1;
   assign TORQUE_EN_CH2        = state_ff.en2;
   assign TORQUE_OFF_ALL       = state_ff.off_all;
   assign BRAKE_CONTROL_ENGAGE = state_ff.brake;
   assign FAILSAFE             = state_ff.failsafe;
   assign OPERATIONAL          = state_ff.op;
   assign RESTART_INHIBIT      = state_ff.inh;
   assign POS_LAG_ERR          = state_ff.pos_err;
   assign SPEED_ERR            = state_ff.spd_err;
   assign FROZEN_ERR           = state_ff.frz_err;
   assign ORDER_ERR            = state_ff.order_err;
   assign STANDSTILL_OK        = state_ff.standstill;
   assign DIR_NEG_MOVE         = state_ff.dir_neg;

   property p_auto_restart;
      @(posedge CLK) disable iff (!RESET_N)
      state_ff.st == dsmc_pkg::ST_INHIBIT && state_ff.cfg.auto_restart && !NET_LOSS
      |=> OPERATIONAL && TORQUE_EN_CH1 && !BRAKE_CONTROL_ENGAGE;
   endproperty
   a_auto_restart: assert property (p_auto_restart) else $error("no auto restart"); // R1

   property p_inhibit_holds;
      @(posedge CLK) disable iff (!RESET_N)
      RESTART_INHIBIT && !state_ff.cfg.auto_restart && !RESTART_ACK
      |=> !OPERATIONAL && !TORQUE_EN_CH1;
   endproperty
   a_inhibit_holds: assert property (p_inhibit_holds) else $error("inhibit left"); // R1

   property p_pos_gate;
      @(posedge CLK) disable iff (!RESET_N)
      $rose(POS_LAG_ERR) |-> $past(state_ff.cfg.pos_mon_en) && $past(OPERATIONAL);
   endproperty
   a_pos_gate: assert property (p_pos_gate) else $error("lag error while off"); // R2

   property p_spd_gate;
      @(posedge CLK) disable iff (!RESET_N)
      OPERATIONAL && !FAILSAFE && state_ff.cfg.spd_mon_en && spd_dev_c
      |=> SPEED_ERR && FAILSAFE;
   endproperty
   a_spd_gate: assert property (p_spd_gate) else $error("speed error missed"); // R3

   property p_frozen;
      @(posedge CLK) disable iff (!RESET_N)
      $rose(FROZEN_ERR) |-> $past(state_ff.cfg.frozen_mon_en) && $past(set_still_c);
   endproperty
   a_frozen: assert property (p_frozen) else $error("bad frozen flag"); // R4

   property p_fs_immediate;
      @(posedge CLK) disable iff (!RESET_N)
      $rose(FAILSAFE) && !state_ff.cfg.fs_delayed
      |-> !TORQUE_EN_CH1 && !TORQUE_EN_CH2 && BRAKE_CONTROL_ENGAGE && TORQUE_OFF_ALL;
   endproperty
   a_fs_immediate: assert property (p_fs_immediate) else $error("slow stop"); // R5

   property p_fs_delayed;
      @(posedge CLK) disable iff (!RESET_N)
      $rose(FAILSAFE) && state_ff.cfg.fs_delayed && $past(OPERATIONAL)
      |-> !TORQUE_EN_CH1 && TORQUE_EN_CH2 && !BRAKE_CONTROL_ENGAGE;
   endproperty
   a_fs_delayed: assert property (p_fs_delayed) else $error("bad first stage"); // R6

   property p_ch2_waits;
      @(posedge CLK) disable iff (!RESET_N)
      state_ff.st == dsmc_pkg::ST_FS_BRAKE &&
      state_ff.cnt < us_to_cycles(state_ff.cfg.brake_delay_us)
      |=> TORQUE_EN_CH2 == $past(TORQUE_EN_CH2) && BRAKE_CONTROL_ENGAGE;
   endproperty
   a_ch2_waits: assert property (p_ch2_waits) else $error("channel two early"); // R7

   property p_hold_cfg;
      @(posedge CLK) disable iff (!RESET_N)
      state_ff.st == dsmc_pkg::ST_LOAD && CFG_LOAD |=> state_ff.cfg == $past(CFG);
   endproperty
   a_hold_cfg: assert property (p_hold_cfg) else $error("limits not held"); // R8 R10

   property p_order;
      @(posedge CLK) disable iff (!RESET_N)
      state_ff.st == dsmc_pkg::ST_CHECK && !order_ok_c && !FAILSAFE
      |=> ORDER_ERR && FAILSAFE && !TORQUE_EN_CH1;
   endproperty
   a_order: assert property (p_order) else $error("order fault missed"); // R9 R11

   property p_standstill;
      @(posedge CLK) disable iff (!RESET_N)
      STANDSTILL_OK |-> $past(spd_in_c);
   endproperty
   a_standstill: assert property (p_standstill) else $error("standstill while moving"); // R12 R13

   property p_latched;
      @(posedge CLK) disable iff (!RESET_N)
      FAILSAFE |=> FAILSAFE [*2] ##0 !OPERATIONAL;
   endproperty
   a_latched: assert property (p_latched) else $error("fail-safe released"); // R14
endmodule : dsmc_monitor

/* logic/dsmc_pkg.sv */
// constants, states and carrier structs of the drive safety monitor
// assumes a single 25 MHz clock domain and synchronous configuration inputs
package dsmc_pkg;
   localparam int CLK_FREQ_HZ = 25_000_000;
   localparam int HZ_PER_MHZ  = 1_000_000;
   localparam int CYC_PER_US  = CLK_FREQ_HZ / HZ_PER_MHZ;
   localparam int DATA_W      = 32;
   localparam int DELAY_W     = 16;
   localparam int LEVELS      = 4;

   typedef enum logic [2:0] {
      ST_LOAD       = 3'h0,
      ST_CHECK      = 3'h1,
      ST_INHIBIT    = 3'h2,
      ST_RUN        = 3'h3,
      ST_FS_CH1_OFF = 3'h4,
      ST_FS_BRAKE   = 3'h5,
      ST_FS_HOLD    = 3'h6
   } dsmc_state_type;

   // speed values are unsigned units/s, positions signed units
   typedef struct packed {
      logic                                auto_restart;
      logic                                pos_mon_en;
      logic                                spd_mon_en;
      logic                                frozen_mon_en;
      logic                                fs_delayed;
      logic [DELAY_W-1:0]                  torque_off_delay_us;
      logic [DELAY_W-1:0]                  brake_delay_us;
      logic [DATA_W-1:0]                   max_speed_limit;
      logic [LEVELS-1:0][DATA_W-1:0]       limited_speed_level;
      logic [DATA_W-1:0]                   normalised_top_speed;
      logic signed [DATA_W-1:0]            full_travel_lo;
      logic signed [DATA_W-1:0]            full_travel_hi;
      logic signed [DATA_W-1:0]            monitored_range_lo;
      logic signed [DATA_W-1:0]            monitored_range_hi;
      logic [DATA_W-1:0]                   standstill_speed_tol;
      logic [DATA_W-1:0]                   standstill_pos_tol;
      logic [DATA_W-1:0]                   enc_pos_tol;
      logic [DATA_W-1:0]                   enc_speed_tol;
   } dsmc_cfg_type;

   typedef struct packed {
      logic signed [DATA_W-1:0] enc_pos;
      logic signed [DATA_W-1:0] enc_speed;
      logic signed [DATA_W-1:0] ref_speed;
      logic signed [DATA_W-1:0] set_pos;
   } dsmc_feed_type;

   // position lag monitor on, everything else off and zero
   localparam dsmc_cfg_type CFG_RESET = '{pos_mon_en: 1'b1, default: '0};
endpackage : dsmc_pkg

/* test/dsmc_axis_model.sv */
// axis model in front of the monitor: setpoint generator, encoder and second speed source
// assumes the bench sets the fault knobs shortly after the rising clock edge
`timescale 1ns/1ps
module dsmc_axis_model (
   input  wire logic                           CLK,
   input  wire logic                           RESET_N,
   input  wire logic signed [dsmc_pkg::DATA_W-1:0] LAG,
   input  wire logic signed [dsmc_pkg::DATA_W-1:0] SPD_OFF,
   input  wire logic                           FREEZE,
   output dsmc_pkg::dsmc_feed_type             FEED
);
   logic signed [dsmc_pkg::DATA_W-1:0] set_pos_ff;

   // setpoint moves one unit per cycle unless frozen, so a stuck generator is the only freeze
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
         set_pos_ff <= '0;
      else if (!FREEZE)
         set_pos_ff <= set_pos_ff + 32'sh1;
   end

   always_comb
   begin
      FEED.set_pos   = set_pos_ff;
      FEED.enc_pos   = set_pos_ff + LAG;
      FEED.ref_speed = FREEZE ? 32'sh0 : 32'sh1;
      FEED.enc_speed = FEED.ref_speed + SPD_OFF;
   end
endmodule : dsmc_axis_model

/* test/test_dsmc_monitor.sv */
// self-checking bench of the drive safety monitor with the axis model on its feed side
// assumes a 25 MHz clock and inputs changed 1 ns after the rising edge
`timescale 1ns/1ps
module test_dsmc_monitor;
   localparam int FROZEN = 4;
   logic                               CLK = 1'b0;
   logic                               RESET_N = 1'b0;
   dsmc_pkg::dsmc_cfg_type             cfg = dsmc_pkg::CFG_RESET;
   logic                               CFG_LOAD = 1'b0;
   logic                               NET_LOSS = 1'b0;
   logic                               RESTART_ACK = 1'b0;
   logic signed [dsmc_pkg::DATA_W-1:0] lag = '0;
   logic signed [dsmc_pkg::DATA_W-1:0] spd_off = '0;
   logic                               freeze = 1'b0;
   dsmc_pkg::dsmc_feed_type            feed;
   logic                               ch1, ch2, off_all, brake, fs, op, inh;
   logic                               plag, serr, ferr, oerr, ss, dneg;
   int                                 errors = 0;
   int                                 tests_run = 0;
   wire logic [6:0]                    outs = {ch1, ch2, brake, off_all, fs, op, inh};
   wire logic [3:0]                    errs = {plag, serr, ferr, oerr};

   dsmc_axis_model AXIS (.CLK(CLK), .RESET_N(RESET_N), .LAG(lag), .SPD_OFF(spd_off),
                         .FREEZE(freeze), .FEED(feed));

   dsmc_monitor #(.FROZEN_CYCLES(FROZEN)) DUT (
      .CLK(CLK), .RESET_N(RESET_N), .CFG(cfg), .CFG_LOAD(CFG_LOAD), .FEED(feed),
      .NET_LOSS(NET_LOSS), .RESTART_ACK(RESTART_ACK), .TORQUE_EN_CH1(ch1),
      .TORQUE_EN_CH2(ch2), .TORQUE_OFF_ALL(off_all), .BRAKE_CONTROL_ENGAGE(brake),
      .FAILSAFE(fs), .OPERATIONAL(op), .RESTART_INHIBIT(inh), .POS_LAG_ERR(plag),
      .SPEED_ERR(serr), .FROZEN_ERR(ferr), .ORDER_ERR(oerr), .STANDSTILL_OK(ss),
      .DIR_NEG_MOVE(dneg));

   initial
   begin
      forever #20 CLK = ~CLK;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : tick

   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      tests_run++;
      if (seen !== expv)
      begin
         errors++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, expv);
      end
   endtask : check

   // w selects: 0 failsafe high, 1 brake high, 2 channel two low; a hang ends at 400
   task automatic wait_for(input int w, output int n);
      logic hit;
      n = 0;
      hit = 1'b0;
      while (!hit && n < 400)
      begin
         tick(1);
         n++;
         hit = (w == 0) ? (fs === 1'b1) : (w == 1) ? (brake === 1'b1) : (ch2 === 1'b0);
      end
   endtask : wait_for

   task automatic do_reset();
      RESET_N = 1'b0;
      CFG_LOAD = 1'b0;
      NET_LOSS = 1'b0;
      RESTART_ACK = 1'b0;
      lag = '0;
      spd_off = '0;
      freeze = 1'b0;
      tick(4);
      RESET_N = 1'b1;
   endtask : do_reset

   // returns one edge after the load edge, where inhibit or an order fault shows
   task automatic load(input dsmc_pkg::dsmc_cfg_type c);
      cfg = c;
      CFG_LOAD = 1'b1;
      tick(1);
      CFG_LOAD = 1'b0;
      tick(1);
   endtask : load

   function automatic dsmc_pkg::dsmc_cfg_type good(input logic auto_on);
      dsmc_pkg::dsmc_cfg_type c;
      c = dsmc_pkg::CFG_RESET;
      c.auto_restart = auto_on;
      c.standstill_speed_tol = 32'h1;
      // index 0 is level one, the highest of the four
      c.limited_speed_level = {32'h2, 32'h3, 32'h4, 32'h5};
      c.max_speed_limit = 32'h6;
      c.normalised_top_speed = 32'h7;
      c.full_travel_lo = -32'sh10;
      c.monitored_range_lo = -32'sh5;
      c.monitored_range_hi = 32'sh5;
      c.full_travel_hi = 32'sh10;
      c.enc_pos_tol = 32'h3;
      c.enc_speed_tol = 32'h2;
      return c;
   endfunction : good

   task automatic t_order();
      dsmc_pkg::dsmc_cfg_type c;
      for (int i = 0; i < 4; i++)
      begin
         do_reset();
         check(outs, 7'h18);
         c = good(1'b1);
         case (i)
            0: c.standstill_speed_tol = 32'h3;
            1: c.limited_speed_level[1] = 32'h6;
            2: c.max_speed_limit = 32'h8;
            default: c.monitored_range_lo = -32'sh11;
         endcase
         load(c);
         check({outs, errs}, {7'h1C, 4'h1});
         load(good(1'b1));
         check({outs, errs}, {7'h1C, 4'h1});
      end
      $display("test order done");
   endtask : t_order

   task automatic t_manual();
      do_reset();
      load(good(1'b0));
      tick(5);
      check(outs, 7'h19);
      NET_LOSS = 1'b1;
      RESTART_ACK = 1'b1;
      tick(2);
      check(outs, 7'h19);
      NET_LOSS = 1'b0;
      tick(1);
      check(outs, 7'h62);
      RESTART_ACK = 1'b0;
      NET_LOSS = 1'b1;
      tick(1);
      check(outs, 7'h19);
      NET_LOSS = 1'b0;
      tick(3);
      check(outs, 7'h19);
      $display("test manual restart done");
   endtask : t_manual

   task automatic t_auto();
      do_reset();
      load(good(1'b1));
      check(outs, 7'h19);
      tick(1);
      check(outs, 7'h62);
      NET_LOSS = 1'b1;
      tick(2);
      check(outs, 7'h19);
      NET_LOSS = 1'b0;
      tick(1);
      check(outs, 7'h62);
      $display("test auto restart done");
   endtask : t_auto

   task automatic t_lag();
      int n;
      do_reset();
      load(good(1'b1));
      tick(1);
      lag = 32'sh3;
      freeze = 1'b1;
      spd_off = 32'sh5;
      tick(1);
      spd_off = '0;
      tick(11);
      check({outs, errs}, {7'h62, 4'h0});
      check({ss, dneg}, 2'h2);
      lag = -32'sh4;
      wait_for(0, n);
      check({outs, errs}, {7'h1C, 4'h8});
      check({ss, dneg}, 2'h1);
      $display("test lag immediate done");
   endtask : t_lag

   task automatic t_delayed();
      dsmc_pkg::dsmc_cfg_type c;
      int n;
      do_reset();
      c = good(1'b1);
      c.pos_mon_en = 1'b0;
      c.spd_mon_en = 1'b1;
      c.fs_delayed = 1'b1;
      c.torque_off_delay_us = 16'h1;
      c.brake_delay_us = 16'h1;
      load(c);
      tick(1);
      lag = 32'sh64;
      spd_off = 32'sh2;
      tick(6);
      check({outs, errs}, {7'h62, 4'h0});
      spd_off = -32'sh3;
      wait_for(0, n);
      check({outs, errs}, {7'h24, 4'h4});
      wait_for(1, n);
      check(n, dsmc_pkg::CYC_PER_US + 1);
      check(outs, 7'h3C);
      wait_for(2, n);
      check(n, dsmc_pkg::CYC_PER_US + 1);
      check(outs, 7'h1C);
      $display("test delayed fail-safe done");
   endtask : t_delayed

   task automatic t_frozen();
      dsmc_pkg::dsmc_cfg_type c;
      int n;
      do_reset();
      c = good(1'b1);
      c.frozen_mon_en = 1'b1;
      load(c);
      tick(1);
      freeze = 1'b1;
      tick(FROZEN - 2);
      check(outs, 7'h62);
      wait_for(0, n);
      check({outs, errs}, {7'h1C, 4'h2});
      check(n, FROZEN);
      $display("test frozen setpoint done");
   endtask : t_frozen

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   initial
   begin
      #(40 * 20000);
      errors++;
      give_verdict();
   end

   initial
   begin
      t_order();
      t_manual();
      t_auto();
      t_lag();
      t_delayed();
      t_frozen();
      give_verdict();
   end
endmodule : test_dsmc_monitor
